// file: hdl/iepb_cfg.svh
// Constants for the interrupt enable and level bank
// Operation
// - Enable register at A8h: global, counter array, timer2, serial, timer1, ext1, timer0, ext0.
// - A set source enable passes that request on; a clear one blocks it.
// - External interrupt 1 passes only while ext1_enable is set.
// - Enable register resets to zero; single bits can be set or cleared.
// - Low level register at B8h, bits 6..0 counter array down to ext0.
// - Low level register resets bits 6..0 clear and is bit addressable.
// - High level register at B7h, same seven sources in same order.
// - High level register resets bits 6..0 clear; whole byte access only.
// - Source level is high bit above low bit.
// - Level 00 is lowest, 11 is highest.
// - A clear global_enable blocks every request.
// - Service is preempted only by a strictly higher level; level 3 never.
// - Equal levels resolve by fixed polling order; higher level always wins.
`ifndef IEPB_CFG_SVH
`define IEPB_CFG_SVH

// ==========================================
// Register offsets
`define IEPB_ENABLE_ADDR 8'ha8
`define IEPB_LEVEL_HIGH_ADDR 8'hb7
`define IEPB_LEVEL_LOW_ADDR 8'hb8

// ==========================================
// Field positions and reset values
`define IEPB_GLOBAL_BIT 7
`define IEPB_NUM_SRC 7
`define IEPB_ENABLE_RESET 8'h00
`define IEPB_LEVEL_RESET 7'h00
`define IEPB_BIT_OP_SET 1'b1

`endif

// file: hdl/iepb_pkg.sv
// Types for the interrupt enable and level bank
package iepb_pkg;
	typedef logic [1:0] iepb_level_t;
	typedef logic [2:0] iepb_src_t;
	typedef enum logic [0:0] {
		IEPB_IDLE = 1'b0,
		IEPB_BUSY = 1'b1
	} iepb_svc_e;
endpackage

// file: hdl/iepb_pick.sv
// Combinational pick of the winning request by level and polling order
`timescale 1ns/1ps
`include "iepb_cfg.svh"
module iepb_pick (
	input wire logic [`IEPB_NUM_SRC-1:0] req_gated,
	input wire logic [2*`IEPB_NUM_SRC-1:0] levels,
	output logic found,
	output iepb_pkg::iepb_src_t win_src,
	output iepb_pkg::iepb_level_t win_level
);
	// Highest level first, lowest index wins ties
	always_comb begin
		found = 1'b0;
		win_src = 3'h0;
		win_level = 2'h0;
		for (int i = `IEPB_NUM_SRC - 1; i >= 0; i--) begin
			if (req_gated[i] && (!found || levels[2*i +: 2] >= win_level)) begin
				found = 1'b1;
				win_src = 3'(i);
				win_level = levels[2*i +: 2];
			end
		end
	end
endmodule // iepb_pick

// file: hdl/iepb_bank.sv
// Enable and level registers with request gating and preemption check
`timescale 1ns/1ps
`include "iepb_cfg.svh"
module iepb_bank (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic bit_wr,
	input wire logic [2:0] bit_pos,
	input wire logic bit_val,
	input wire logic [`IEPB_NUM_SRC-1:0] src_req,
	input wire logic svc_done,
	input wire logic svc_take,
	output logic [`IEPB_NUM_SRC-1:0] src_enable,
	output logic [2*`IEPB_NUM_SRC-1:0] src_level,
	output logic irq_valid,
	output logic [2:0] irq_src,
	output logic [1:0] irq_level,
	output logic in_service
);
	// ==========================================
	// State
	typedef struct packed {
		logic [7:0] enable;
		logic [6:0] lvl_high;
		logic [6:0] lvl_low;
		logic [7:0] rdata;
		iepb_pkg::iepb_svc_e svc;
		iepb_pkg::iepb_level_t svc_level;
	} iepb_state_s;

	iepb_state_s st_reg;
	iepb_state_s st_next;
	logic [`IEPB_NUM_SRC-1:0] req_gated;
	logic [2*`IEPB_NUM_SRC-1:0] levels;
	logic found;
	iepb_pkg::iepb_src_t win_src;
	iepb_pkg::iepb_level_t win_level;
	logic preempt_ok;

	// ==========================================
	// Per-source gating and level forming
	genvar g;
	generate
		for (g = 0; g < `IEPB_NUM_SRC; g++) begin : g_src
			assign req_gated[g] = src_req[g] & st_reg.enable[g] & st_reg.enable[`IEPB_GLOBAL_BIT];
			assign levels[2*g +: 2] = {st_reg.lvl_high[g], st_reg.lvl_low[g]};
		end
	endgenerate

	iepb_pick u_pick (
		.req_gated(req_gated),
		.levels(levels),
		.found(found),
		.win_src(win_src),
		.win_level(win_level)
	);

	// Strictly higher level preempts, level 3 never preempted
	assign preempt_ok = (st_reg.svc == iepb_pkg::IEPB_IDLE) ||
		((st_reg.svc_level != 2'h3) && (win_level > st_reg.svc_level));

	// Request and level out to the core arbiter
	assign irq_valid = found & preempt_ok;
	assign irq_src = win_src;
	assign irq_level = win_level;
	assign src_enable = {`IEPB_NUM_SRC{st_reg.enable[`IEPB_GLOBAL_BIT]}} &
		st_reg.enable[`IEPB_NUM_SRC-1:0];
	assign src_level = levels;
	assign rdata = st_reg.rdata;
	assign in_service = (st_reg.svc == iepb_pkg::IEPB_BUSY);

	// ==========================================
	// Next state
	always_comb begin
		st_next = st_reg;
		if (wr_en && addr == `IEPB_ENABLE_ADDR) begin
			st_next.enable = wdata;
		end
		// Byte write of high level; bit 7 dropped
		if (wr_en && addr == `IEPB_LEVEL_HIGH_ADDR) begin
			st_next.lvl_high = wdata[6:0];
		end
		// Byte write of low level register
		if (wr_en && addr == `IEPB_LEVEL_LOW_ADDR) begin
			st_next.lvl_low = wdata[6:0];
		end
		// Single bit ops; high level excluded
		if (bit_wr && addr == `IEPB_ENABLE_ADDR) begin
			st_next.enable[bit_pos] = bit_val;
		end
		if (bit_wr && addr == `IEPB_LEVEL_LOW_ADDR && bit_pos != 3'h7) begin
			st_next.lvl_low[bit_pos] = bit_val;
		end
		// Read data one cycle later, reserved bit 7 reads zero
		st_next.rdata = 8'h00;
		if (rd_en) begin
			unique case (addr)
				`IEPB_ENABLE_ADDR: st_next.rdata = st_reg.enable;
				`IEPB_LEVEL_HIGH_ADDR: st_next.rdata = {1'b0, st_reg.lvl_high};
				`IEPB_LEVEL_LOW_ADDR: st_next.rdata = {1'b0, st_reg.lvl_low};
				default: st_next.rdata = 8'h00;
			endcase
		end
		// Service tracking for the preemption check
		if (svc_take && irq_valid) begin
			st_next.svc = iepb_pkg::IEPB_BUSY;
			st_next.svc_level = win_level;
		end else if (svc_done) begin
			st_next.svc = iepb_pkg::IEPB_IDLE;
			st_next.svc_level = 2'h0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_reg.enable <= `IEPB_ENABLE_RESET;
			st_reg.lvl_high <= `IEPB_LEVEL_RESET;
			st_reg.lvl_low <= `IEPB_LEVEL_RESET;
			st_reg.rdata <= 8'h00;
			st_reg.svc <= iepb_pkg::IEPB_IDLE;
			st_reg.svc_level <= 2'h0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// Checks
	property p_global_block;
		@(posedge clock) disable iff (!nrst)
		!st_reg.enable[`IEPB_GLOBAL_BIT] |-> !irq_valid;
	endproperty
	a_global_block: assert property (p_global_block) else $error("request with global off");

	property p_src_gate;
		@(posedge clock) disable iff (!nrst)
		irq_valid |-> st_reg.enable[irq_src] && src_req[irq_src];
	endproperty
	a_src_gate: assert property (p_src_gate) else $error("disabled source passed");

	property p_ext1_gate;
		@(posedge clock) disable iff (!nrst)
		!st_reg.enable[2] |-> !req_gated[2];
	endproperty
	a_ext1_gate: assert property (p_ext1_gate) else $error("ext1 passed while off");

	property p_enable_write;
		@(posedge clock) disable iff (!nrst)
		wr_en && addr == `IEPB_ENABLE_ADDR |=> st_reg.enable == $past(wdata);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");

	property p_high_no_bit;
		@(posedge clock) disable iff (!nrst)
		bit_wr && !wr_en |=> st_reg.lvl_high == $past(st_reg.lvl_high);
	endproperty
	a_high_no_bit: assert property (p_high_no_bit) else $error("high level bit write");

	property p_low_bit;
		@(posedge clock) disable iff (!nrst)
		bit_wr && !wr_en && addr == `IEPB_LEVEL_LOW_ADDR && bit_pos != 3'h7
		|=> st_reg.lvl_low[$past(bit_pos)] == $past(bit_val);
	endproperty
	a_low_bit: assert property (p_low_bit) else $error("low level bit write lost");

	property p_no_preempt_top;
		@(posedge clock) disable iff (!nrst)
		in_service && st_reg.svc_level == 2'h3 |-> !irq_valid;
	endproperty
	a_no_preempt_top: assert property (p_no_preempt_top) else $error("level 3 preempted");

	property p_level_form;
		@(posedge clock) disable iff (!nrst)
		irq_valid |-> irq_level == {st_reg.lvl_high[irq_src], st_reg.lvl_low[irq_src]};
	endproperty
	a_level_form: assert property (p_level_form) else $error("level not high then low");

	property p_read_enable;
		@(posedge clock) disable iff (!nrst)
		rd_en && addr == `IEPB_ENABLE_ADDR |=> rdata == $past(st_reg.enable);
	endproperty
	a_read_enable: assert property (p_read_enable) else $error("enable readback wrong");

	// ==========================================
	// Access and service steps
	// Byte write to the enable register
	sequence s_enable_write;
		wr_en && addr == `IEPB_ENABLE_ADDR;
	endsequence

	// Byte write to the high level register
	sequence s_high_write;
		wr_en && addr == `IEPB_LEVEL_HIGH_ADDR;
	endsequence

	// Byte write to the low level register
	sequence s_low_write;
		wr_en && !bit_wr && addr == `IEPB_LEVEL_LOW_ADDR;
	endsequence

	// Read strobe at the high level register
	sequence s_read_high;
		rd_en && addr == `IEPB_LEVEL_HIGH_ADDR;
	endsequence

	// Read strobe at the low level register
	sequence s_read_low;
		rd_en && addr == `IEPB_LEVEL_LOW_ADDR;
	endsequence

	// Single bit write to the enable register
	sequence s_enable_bit;
		bit_wr && !wr_en && addr == `IEPB_ENABLE_ADDR;
	endsequence

	// Single bit write aimed at the reserved low level bit
	sequence s_low_bit7;
		bit_wr && !wr_en && addr == `IEPB_LEVEL_LOW_ADDR && bit_pos == 3'h7;
	endsequence

	// Core accepts the current winner
	sequence s_take;
		svc_take && irq_valid;
	endsequence

	// Core ends service with no new take beside it
	sequence s_done;
		svc_done && !(svc_take && irq_valid);
	endsequence

	// ==========================================
	// Register and arbitration checks
	property p_enable_hold;
		@(posedge clock) disable iff (!nrst)
		!wr_en && !bit_wr |=> $stable(st_reg.enable);
	endproperty
	a_enable_hold: assert property (p_enable_hold) else $error("enable changed unasked");

	property p_enable_full;
		@(posedge clock) disable iff (!nrst)
		s_enable_write |=> st_reg.enable == $past(wdata);
	endproperty
	a_enable_full: assert property (p_enable_full) else $error("enable byte lost");

	property p_high_write;
		@(posedge clock) disable iff (!nrst)
		s_high_write |=> st_reg.lvl_high == $past(wdata[6:0]);
	endproperty
	a_high_write: assert property (p_high_write) else $error("high level write lost");

	property p_low_write;
		@(posedge clock) disable iff (!nrst)
		s_low_write |=> st_reg.lvl_low == $past(wdata[6:0]);
	endproperty
	a_low_write: assert property (p_low_write) else $error("low level write lost");

	property p_read_high;
		@(posedge clock) disable iff (!nrst)
		s_read_high |=> rdata[6:0] == $past(st_reg.lvl_high);
	endproperty
	a_read_high: assert property (p_read_high) else $error("high level readback wrong");

	property p_read_low;
		@(posedge clock) disable iff (!nrst)
		s_read_low |=> rdata[6:0] == $past(st_reg.lvl_low);
	endproperty
	a_read_low: assert property (p_read_low) else $error("low level readback wrong");

	property p_reserved_high;
		@(posedge clock) disable iff (!nrst)
		s_read_high |=> !rdata[7];
	endproperty
	a_reserved_high: assert property (p_reserved_high) else $error("high bit 7 set");

	property p_reserved_low;
		@(posedge clock) disable iff (!nrst)
		s_read_low |=> !rdata[7];
	endproperty
	a_reserved_low: assert property (p_reserved_low) else $error("low bit 7 set");

	property p_enable_bit;
		@(posedge clock) disable iff (!nrst)
		s_enable_bit |=> st_reg.enable[$past(bit_pos)] == $past(bit_val);
	endproperty
	a_enable_bit: assert property (p_enable_bit) else $error("enable bit write lost");

	property p_low_bit7;
		@(posedge clock) disable iff (!nrst)
		s_low_bit7 |=> $stable(st_reg.lvl_low);
	endproperty
	a_low_bit7: assert property (p_low_bit7) else $error("reserved low bit taken");

	property p_take;
		@(posedge clock) disable iff (!nrst)
		s_take |=> in_service && st_reg.svc_level == $past(irq_level);
	endproperty
	a_take: assert property (p_take) else $error("service level not held");

	property p_done;
		@(posedge clock) disable iff (!nrst)
		s_done |=> !in_service;
	endproperty
	a_done: assert property (p_done) else $error("service did not end");

	property p_preempt_higher;
		@(posedge clock) disable iff (!nrst)
		in_service && irq_valid |-> irq_level > st_reg.svc_level;
	endproperty
	a_preempt_higher: assert property (p_preempt_higher) else $error("preempt not higher");

	property p_win_gated;
		@(posedge clock) disable iff (!nrst)
		irq_valid |-> req_gated[irq_src];
	endproperty
	a_win_gated: assert property (p_win_gated) else $error("winner not gated in");

	property p_idle_pass;
		@(posedge clock) disable iff (!nrst)
		!in_service && found |-> irq_valid;
	endproperty
	a_idle_pass: assert property (p_idle_pass) else $error("idle request held back");

	property p_global_out;
		@(posedge clock) disable iff (!nrst)
		!st_reg.enable[`IEPB_GLOBAL_BIT] |-> src_enable == 7'h00;
	endproperty
	a_global_out: assert property (p_global_out) else $error("enable out with global off");

	property p_ext1_pass;
		@(posedge clock) disable iff (!nrst)
		st_reg.enable[`IEPB_GLOBAL_BIT] && st_reg.enable[2] && src_req[2] |-> found;
	endproperty
	a_ext1_pass: assert property (p_ext1_pass) else $error("ext1 not passed");

	property p_win_level;
		@(posedge clock) disable iff (!nrst)
		irq_valid |-> irq_level == src_level[2*irq_src +: 2];
	endproperty
	a_win_level: assert property (p_win_level) else $error("winner level mismatch");

	property p_tie_low;
		@(posedge clock) disable iff (!nrst)
		irq_valid && irq_src != 3'h0 && req_gated[0] |-> levels[1:0] < irq_level;
	endproperty
	a_tie_low: assert property (p_tie_low) else $error("tie not to lowest index");

	property p_higher_wins;
		@(posedge clock) disable iff (!nrst)
		irq_valid && req_gated[6] |-> levels[13:12] <= irq_level;
	endproperty
	a_higher_wins: assert property (p_higher_wins) else $error("lower level won");
endmodule // iepb_bank

// file: sim/iepb_core_model.sv
// Model of request sources and of the core that takes and ends service
`timescale 1ns/1ps
module iepb_core_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [6:0] req_cmd,
	input wire logic take_cmd,
	input wire logic done_cmd,
	output logic [6:0] src_req,
	output logic svc_take,
	output logic svc_done
);
	// ==========
	// Launch requests and service pulses just after the edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			src_req <= 7'h00;
			svc_take <= 1'b0;
			svc_done <= 1'b0;
		end else begin
			src_req <= req_cmd;
			svc_take <= take_cmd;
			svc_done <= done_cmd;
		end
	end
endmodule // iepb_core_model

// file: sim/iepb_bank_test.sv
// Self-checking bench for the interrupt enable and level bank
`timescale 1ns/1ps
`include "iepb_cfg.svh"
module iepb_bank_test;
	localparam logic [7:0] a_en = `IEPB_ENABLE_ADDR, a_hi = `IEPB_LEVEL_HIGH_ADDR;
	localparam logic [7:0] a_lo = `IEPB_LEVEL_LOW_ADDR;
	logic clock = 0, nrst = 0, wr_en = 0, rd_en = 0, bit_wr = 0, bit_val = 0;
	logic take_cmd = 0, done_cmd = 0, svc_take, svc_done, irq_valid, in_service;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [6:0] req_cmd = 7'h00, src_req, src_enable;
	logic [2:0] bit_pos = 3'h0, irq_src;
	logic [1:0] irq_level;
	logic [13:0] src_level;
	int errors = 0, check_count = 0;
	// ==========
	// Design and far-side model
	iepb_bank u_iepb_bank (.clock, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .bit_wr,
		.bit_pos, .bit_val, .src_req, .svc_done, .svc_take, .src_enable, .src_level,
		.irq_valid, .irq_src, .irq_level, .in_service);
	iepb_core_model u_iepb_core_model (.clock, .nrst, .req_cmd, .take_cmd, .done_cmd,
		.src_req, .svc_take, .svc_done);
	// Clock and watchdog
	initial begin
		forever #20 clock = ~clock;
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
	// ==========
	// Shared tasks
	task chk(input string name, input logic [13:0] exp, input logic [13:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Byte write, or bit write with position d[2:0] and value d[3]
	task wr(input logic [7:0] a, input logic [7:0] d, input logic b);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		bit_pos <= d[2:0];
		bit_val <= d[3];
		wr_en <= !b;
		bit_wr <= b;
		@(posedge clock);
		wr_en <= 1'b0;
		bit_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 chk("rdata", {6'h00, exp}, {6'h00, rdata});
	endtask
	task rq(input logic [6:0] r);
		@(posedge clock);
		req_cmd <= r;
		@(posedge clock);
		#1;
	endtask
	task sv(input logic t, input logic d);
		@(posedge clock);
		take_cmd <= t;
		done_cmd <= d;
		@(posedge clock);
		take_cmd <= 1'b0;
		done_cmd <= 1'b0;
		@(posedge clock);
		#1;
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ==========
	// Scenarios
	task t_reset;
		rd(a_en, 8'h00);
		rd(a_hi, 8'h00);
		rd(a_lo, 8'h00);
		rd(8'ha9, 8'h00);
		$display("t_reset done");
	endtask
	task t_regs;
		wr(a_hi, 8'h35, 0);
		wr(a_lo, 8'h53, 0);
		rd(a_hi, 8'h35);
		rd(a_lo, 8'h53);
		chk("src_level", 14'h1b27, src_level);
		$display("t_regs done");
	endtask
	task t_enable;
		rq(7'h7f);
		for (int i = 0; i < 7; i++) begin
			wr(a_en, 8'h80 | (8'h01 << i), 0);
			chk("src_enable", 14'(7'h01 << i), {7'h00, src_enable});
			chk("win", 14'(i), {10'h0, irq_valid ^ 1'b1, irq_src});
		end
		wr(a_en, 8'h7f, 0);
		chk("global off", 14'h0, {6'h0, src_enable, irq_valid});
		rd(a_en, 8'h7f);
		$display("t_enable done");
	endtask
	task t_bits;
		wr(a_en, 8'h0f, 1);
		wr(a_en, 8'h02, 1);
		rd(a_en, 8'hfb);
		rq(7'h04);
		chk("ext1 blocked", 14'h0, {13'h0, irq_valid});
		wr(a_hi, 8'h08, 1);
		rd(a_hi, 8'h35);
		wr(a_lo, 8'h0a, 1);
		rd(a_lo, 8'h57);
		$display("t_bits done");
	endtask
	task t_prio;
		rq(7'h7f);
		chk("tie", 14'h23, {8'h0, irq_valid, irq_src, irq_level});
		rq(7'h70);
		chk("higher", 14'h33, {8'h0, irq_valid, irq_src, irq_level});
		rq(7'h40);
		sv(1, 0);
		rq(7'h42);
		chk("equal held", 14'h2, {12'h0, in_service, irq_valid});
		rq(7'h60);
		chk("preempt", 14'h36, {8'h0, irq_valid, irq_src, irq_level});
		sv(0, 1);
		chk("ended", 14'h0, {13'h0, in_service});
		rq(7'h10);
		sv(1, 0);
		rq(7'h11);
		chk("top held", 14'h2, {12'h0, in_service, irq_valid});
		sv(0, 1);
		$display("t_prio done");
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_regs();
		t_enable();
		t_bits();
		t_prio();
		end_of_test();
	end
endmodule // iepb_bank_test
